// ---- design/bstap_fsm.sv ----
// Sixteen-state test access port controller
`timescale 1ns/1ns
module bstap_fsm
   import bstap_pkg::*;
(
   bstap_link_if.fsm lk
);
   bstap_state_t st_ff;
   bstap_state_t nxt_st;

   always_comb begin
      unique case (st_ff)
         ST_TLR: nxt_st = lk.tms ? ST_TLR : ST_RTI;
         ST_RTI: nxt_st = lk.tms ? ST_SEL_DAT : ST_RTI;
         ST_SEL_DAT: nxt_st = lk.tms ? ST_SEL_INS : ST_CAP_DAT;
         ST_CAP_DAT: nxt_st = lk.tms ? ST_EX1_DAT : ST_SHF_DAT;
         ST_SHF_DAT: nxt_st = lk.tms ? ST_EX1_DAT : ST_SHF_DAT;
         ST_EX1_DAT: nxt_st = lk.tms ? ST_UPD_DAT : ST_PAU_DAT;
         ST_PAU_DAT: nxt_st = lk.tms ? ST_EX2_DAT : ST_PAU_DAT;
         ST_EX2_DAT: nxt_st = lk.tms ? ST_UPD_DAT : ST_SHF_DAT;
         ST_UPD_DAT: nxt_st = lk.tms ? ST_SEL_DAT : ST_RTI;
         ST_SEL_INS: nxt_st = lk.tms ? ST_TLR : ST_CAP_INS;
         ST_CAP_INS: nxt_st = lk.tms ? ST_EX1_INS : ST_SHF_INS;
         ST_SHF_INS: nxt_st = lk.tms ? ST_EX1_INS : ST_SHF_INS;
         ST_EX1_INS: nxt_st = lk.tms ? ST_UPD_INS : ST_PAU_INS;
         ST_PAU_INS: nxt_st = lk.tms ? ST_EX2_INS : ST_PAU_INS;
         ST_EX2_INS: nxt_st = lk.tms ? ST_UPD_INS : ST_SHF_INS;
         ST_UPD_INS: nxt_st = lk.tms ? ST_SEL_DAT : ST_RTI;
      endcase
   end

   // TMS is sampled on the rising edge only
   always_ff @(posedge lk.tck) begin
      if (lk.rst) begin
         st_ff <= ST_TLR;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign lk.st = st_ff;
endmodule // bstap_fsm

// ---- design/bstap_top.sv ----
// Boundary-scan test access port with instruction and data registers
`timescale 1ns/1ns
`include "bstap_params.svh"
module bstap_top
   import bstap_pkg::*;
#(
   parameter int INS_W = 8,
   parameter int CELL_W = 18,
   parameter int CTRL_W = 11
) (
   input wire logic CLK,
   input wire logic NRST,
   input wire logic TCK,
   input wire logic TMS,
   input wire logic TDI,
   output logic TDO,
   output logic TDO_OE,
   output logic [INS_W-1:0] INSTR,
   output logic TEST_MODE,
   output logic RUN_TEST,
   output logic [CELL_W-1:0] CELL_OUT,
   output logic [CTRL_W-1:0] CTRL_OUT
);
   localparam int WORD_W = 2 + INS_W + CELL_W + CTRL_W;

   generate
      if (INS_W != $bits(`BSTAP_INS_RESET)) begin : g_bad_ins
         $error("Instruction width must be eight");
      end
      if (CELL_W != $bits(`BSTAP_CELL_RESET)) begin : g_bad_cell
         $error("Boundary chain width does not match its reset value");
      end
      if (CTRL_W != $bits(`BSTAP_CTRL_RESET)) begin : g_bad_ctrl
         $error("Control chain width does not match its reset value");
      end
   endgenerate

   bstap_link_if lk ();

   logic rst_s1_ff, rst_s2_ff, rst_s3_ff;
   logic link_rst_ff;
   logic [INS_W-1:0] instr_shift_ff;
   logic [INS_W-1:0] instr_lat_ff;
   logic byp_ff;
   logic [CELL_W-1:0] cell_shift_ff;
   logic [CELL_W-1:0] cell_lat_ff;
   logic [CTRL_W-1:0] ctrl_shift_ff;
   logic [CTRL_W-1:0] ctrl_lat_ff;
   logic tdo_ff;
   logic tdo_oe_ff;
   bstap_sel_t cur_sel;
   logic run_now;
   logic test_now;
   logic dr_shift;
   logic [WORD_W-1:0] src_word;
   logic [WORD_W-1:0] dst_word;

   // Core reset into the TCK domain; holds only while TCK runs
   always_ff @(posedge TCK) begin
      rst_s1_ff <= NRST;
      rst_s2_ff <= rst_s1_ff;
      rst_s3_ff <= rst_s2_ff;
      if (rst_s2_ff == rst_s3_ff) begin
         link_rst_ff <= ~rst_s3_ff;
      end
   end

   assign lk.tck = TCK;
   assign lk.rst = link_rst_ff;
   assign lk.tms = TMS;

   bstap_fsm u_fsm (
      .lk (lk)
   );

   assign cur_sel = bstap_select(instr_lat_ff);
   assign test_now = bstap_is_test(instr_lat_ff);
   // Tester has to go through Run-Test/Idle first, so a running test never skips it
   assign run_now = (lk.st == ST_RTI) && !(^instr_lat_ff) &&
      (instr_lat_ff == `BSTAP_OP_RUNT);
   assign dr_shift = (lk.st == ST_SHF_DAT);

   // Instruction shift stage
   always_ff @(posedge TCK) begin
      if (link_rst_ff) begin
         instr_shift_ff <= `BSTAP_INS_RESET;
      end else begin
         unique case (lk.st)
            ST_CAP_INS: instr_shift_ff <= `BSTAP_INS_CAPTURE;
            ST_SHF_INS: instr_shift_ff <= {TDI, instr_shift_ff[INS_W-1:1]};
            default: instr_shift_ff <= instr_shift_ff;
         endcase
      end
   end

   // Bypass stage has no latch behind it
   always_ff @(posedge TCK) begin
      if (link_rst_ff) begin
         byp_ff <= 1'b0;
      end else if (cur_sel == SEL_BYPASS) begin
         if (lk.st == ST_CAP_DAT) begin
            byp_ff <= 1'b0;
         end else if (dr_shift) begin
            byp_ff <= TDI;
         end
      end
   end

   // Boundary shift stage captures its own latches; pin sampling lives outside
   always_ff @(posedge TCK) begin
      if (link_rst_ff || lk.st == ST_TLR) begin
         cell_shift_ff <= `BSTAP_CELL_RESET;
      end else if (cur_sel == SEL_CELL) begin
         if (lk.st == ST_CAP_DAT) begin
            cell_shift_ff <= cell_lat_ff;
         end else if (dr_shift) begin
            cell_shift_ff <= {TDI, cell_shift_ff[CELL_W-1:1]};
         end
      end
   end

   // Control chain keeps its contents through Capture-DR
   always_ff @(posedge TCK) begin
      if (link_rst_ff || lk.st == ST_TLR) begin
         ctrl_shift_ff <= `BSTAP_CTRL_RESET;
      end else if (cur_sel == SEL_CTRL && dr_shift) begin
         ctrl_shift_ff <= {TDI, ctrl_shift_ff[CTRL_W-1:1]};
      end
   end

   // Instruction latch moves on the falling edge so decode is settled by the next rise
   always_ff @(negedge TCK) begin
      if (link_rst_ff || lk.st == ST_TLR) begin
         instr_lat_ff <= `BSTAP_INS_RESET;
      end else if (lk.st == ST_UPD_INS) begin
         instr_lat_ff <= instr_shift_ff;
      end
   end

   always_ff @(negedge TCK) begin
      if (link_rst_ff || lk.st == ST_TLR) begin
         cell_lat_ff <= `BSTAP_CELL_RESET;
      end else if (lk.st == ST_UPD_DAT && cur_sel == SEL_CELL) begin
         cell_lat_ff <= cell_shift_ff;
      end
   end

   always_ff @(negedge TCK) begin
      if (link_rst_ff || lk.st == ST_TLR) begin
         ctrl_lat_ff <= `BSTAP_CTRL_RESET;
      end else if (lk.st == ST_UPD_DAT && cur_sel == SEL_CTRL) begin
         ctrl_lat_ff <= ctrl_shift_ff;
      end
   end

   // Serial output changes only on the falling edge
   always_ff @(negedge TCK) begin
      if (link_rst_ff) begin
         tdo_ff <= 1'b0;
         tdo_oe_ff <= 1'b0;
      end else begin
         tdo_oe_ff <= (lk.st == ST_SHF_DAT) || (lk.st == ST_SHF_INS);
         if (lk.st == ST_SHF_INS) begin
            tdo_ff <= instr_shift_ff[0];
         end else begin
            unique case (cur_sel)
               SEL_CELL: tdo_ff <= cell_shift_ff[0];
               SEL_CTRL: tdo_ff <= ctrl_shift_ff[0];
               default: tdo_ff <= byp_ff;
            endcase
         end
      end
   end

   assign TDO = tdo_ff;
   assign TDO_OE = tdo_oe_ff;

   // Status word handed to the system clock for the rest of the chip
   assign src_word = {run_now, test_now, instr_lat_ff, cell_lat_ff, ctrl_lat_ff};

   bstap_xfer #(
      .WIDTH (WORD_W)
   ) u_xfer (
      .src_clk (TCK),
      .src_rst (link_rst_ff),
      .src_word (src_word),
      .dst_clk (CLK),
      .dst_rst_n (NRST),
      .dst_word (dst_word)
   );

   assign RUN_TEST = dst_word[WORD_W-1];
   assign TEST_MODE = dst_word[WORD_W-2];
   assign INSTR = dst_word[WORD_W-3 -: INS_W];
   assign CELL_OUT = dst_word[CTRL_W +: CELL_W];
   assign CTRL_OUT = dst_word[CTRL_W-1:0];

   tlr_reach_a: assert property (
      @(posedge TCK) disable iff (link_rst_ff)
      TMS [*5] |=> (lk.st == ST_TLR))
      else $error("Five cycles of TMS high did not reach reset state");

   power_up_a: assert property (
      @(posedge TCK)
      link_rst_ff |=> (lk.st == ST_TLR))
      else $error("Controller not in reset state after power-up reset");

   ins_reset_a: assert property (
      @(posedge TCK) disable iff (link_rst_ff)
      (lk.st == ST_TLR) ##1 (lk.st == ST_TLR)
      |-> (instr_lat_ff == `BSTAP_INS_RESET) && (cur_sel == SEL_BYPASS))
      else $error("Instruction latch not forced to bypass in reset state");

   cell_reset_a: assert property (
      @(posedge TCK) disable iff (link_rst_ff)
      (lk.st == ST_TLR) |=> (cell_shift_ff == `BSTAP_CELL_RESET)
      && (cell_lat_ff == `BSTAP_CELL_RESET))
      else $error("Boundary cells not at reset pattern");

   ctrl_reset_a: assert property (
      @(posedge TCK) disable iff (link_rst_ff)
      (lk.st == ST_TLR) |=> (ctrl_lat_ff == `BSTAP_CTRL_RESET))
      else $error("Control chain not at reset pattern");

   run_gate_a: assert property (
      @(posedge TCK) disable iff (link_rst_ff)
      (lk.st != ST_RTI) |-> !run_now)
      else $error("Test operation active outside Run-Test/Idle");

   select_pass_a: assert property (
      @(posedge TCK) disable iff (link_rst_ff)
      (lk.st == ST_SEL_INS) |=> (lk.st == ST_TLR) || (lk.st == ST_CAP_INS))
      else $error("Instruction select state not left after one cycle");

   byp_capture_a: assert property (
      @(posedge TCK) disable iff (link_rst_ff)
      (lk.st == ST_CAP_DAT) && (cur_sel == SEL_BYPASS) |=> !byp_ff)
      else $error("Bypass stage did not capture zero");

   tdo_on_a: assert property (
      @(posedge TCK) disable iff (link_rst_ff)
      (lk.st == ST_SHF_INS) |-> tdo_oe_ff && (tdo_ff == instr_shift_ff[0]))
      else $error("TDO not driving instruction LSB during shift");

   shift_step_a: assert property (
      @(posedge TCK) disable iff (link_rst_ff)
      (lk.st == ST_SHF_INS) |=>
      (instr_shift_ff == {$past(TDI), $past(instr_shift_ff[INS_W-1:1])}))
      else $error("Instruction stage did not shift by one bit");

   no_entry_shift_a: assert property (
      @(posedge TCK) disable iff (link_rst_ff)
      (lk.st == ST_EX2_DAT) ##1 (lk.st == ST_SHF_DAT) |-> $stable(cell_shift_ff))
      else $error("Boundary stage shifted in the entry cycle");

   tdo_off_a: assert property (
      @(posedge TCK) disable iff (link_rst_ff)
      (lk.st == ST_EX1_DAT) || (lk.st == ST_EX1_INS) |-> !tdo_oe_ff)
      else $error("TDO still enabled in Exit1");

   pause_hold_a: assert property (
      @(posedge TCK) disable iff (link_rst_ff)
      (lk.st == ST_PAU_DAT) |=> $stable(cell_shift_ff) && $stable(ctrl_shift_ff)
      && $stable(byp_ff))
      else $error("Data stages changed during pause");

   upd_dat_a: assert property (
      @(posedge TCK) disable iff (link_rst_ff)
      (lk.st == ST_UPD_DAT) && (cur_sel == SEL_CTRL) |-> (ctrl_lat_ff == ctrl_shift_ff))
      else $error("Control latches not updated in Update-DR");

   cap_ins_a: assert property (
      @(posedge TCK) disable iff (link_rst_ff)
      (lk.st == ST_CAP_INS) |=> (instr_shift_ff == `BSTAP_INS_CAPTURE))
      else $error("Status pattern not captured in Capture-IR");

   upd_ins_a: assert property (
      @(posedge TCK) disable iff (link_rst_ff)
      (lk.st == ST_UPD_INS) |-> (instr_lat_ff == instr_shift_ff))
      else $error("Instruction latch not updated in Update-IR");

   parity_byp_a: assert property (
      @(posedge TCK) disable iff (link_rst_ff)
      (^instr_lat_ff) |-> (cur_sel == SEL_BYPASS) && !test_now)
      else $error("Odd-parity opcode did not fall back to bypass");

   sel_dat_pass_a: assert property (
      @(posedge TCK) disable iff (link_rst_ff)
      (lk.st == ST_SEL_DAT) |=> (lk.st == ST_SEL_INS) || (lk.st == ST_CAP_DAT))
      else $error("Data select state not left after one cycle");

   cell_capture_a: assert property (
      @(posedge TCK) disable iff (link_rst_ff)
      (lk.st == ST_CAP_DAT) && (cur_sel == SEL_CELL) |=>
      (cell_shift_ff == $past(cell_lat_ff)))
      else $error("Boundary stage did not capture its latches");

   ctrl_keep_a: assert property (
      @(posedge TCK) disable iff (link_rst_ff)
      (lk.st == ST_CAP_DAT) |=> $stable(ctrl_shift_ff))
      else $error("Control chain changed in Capture-DR");

   tdo_cell_a: assert property (
      @(posedge TCK) disable iff (link_rst_ff)
      (lk.st == ST_SHF_DAT) && (cur_sel == SEL_CELL) |->
      tdo_oe_ff && (tdo_ff == cell_shift_ff[0]))
      else $error("TDO not driving boundary LSB during shift");

   exit_keep_a: assert property (
      @(posedge TCK) disable iff (link_rst_ff)
      (lk.st == ST_EX2_DAT) |=> $stable(cell_shift_ff) && $stable(ctrl_shift_ff)
      && $stable(byp_ff))
      else $error("Data stages reloaded before returning to shift");

   lat_hold_a: assert property (
      @(posedge TCK) disable iff (link_rst_ff)
      (lk.st != ST_UPD_DAT) && (lk.st != ST_TLR) |->
      $stable(cell_lat_ff) && $stable(ctrl_lat_ff))
      else $error("Data latches changed outside Update-DR");

   ins_hold_a: assert property (
      @(posedge TCK) disable iff (link_rst_ff)
      (lk.st != ST_UPD_INS) && (lk.st != ST_TLR) |-> $stable(instr_lat_ff))
      else $error("Instruction latch changed outside Update-IR");

   unimpl_byp_a: assert property (
      @(posedge TCK) disable iff (link_rst_ff)
      (instr_lat_ff == 8'h81) || (instr_lat_ff == 8'h84) |->
      (cur_sel == SEL_BYPASS) && !test_now)
      else $error("Unimplemented opcode did not act as bypass");

endmodule // bstap_top

// ---- design/bstap_xfer.sv ----
// Request/acknowledge handover of a status word between two clocks
`timescale 1ns/1ns
module bstap_xfer #(
   parameter int WIDTH = 8
) (
   input wire logic src_clk,
   input wire logic src_rst,
   input wire logic [WIDTH-1:0] src_word,
   input wire logic dst_clk,
   input wire logic dst_rst_n,
   output logic [WIDTH-1:0] dst_word
);
   logic req_ff;
   logic [WIDTH-1:0] snap_ff;
   logic ack_s1_ff, ack_s2_ff, ack_s3_ff, ack_seen_ff;
   logic req_s1_ff, req_s2_ff, req_s3_ff, ack_ff;

   // Snapshot stays frozen until the far side has acknowledged it
   always_ff @(posedge src_clk) begin
      if (src_rst) begin
         req_ff <= 1'b0;
         snap_ff <= '0;
         ack_s1_ff <= 1'b0;
         ack_s2_ff <= 1'b0;
         ack_s3_ff <= 1'b0;
         ack_seen_ff <= 1'b0;
      end else begin
         ack_s1_ff <= ack_ff;
         ack_s2_ff <= ack_s1_ff;
         ack_s3_ff <= ack_s2_ff;
         if (ack_s2_ff == ack_s3_ff) begin
            ack_seen_ff <= ack_s3_ff;
         end
         if (req_ff == ack_seen_ff && snap_ff != src_word) begin
            snap_ff <= src_word;
            req_ff <= ~req_ff;
         end
      end
   end

   always_ff @(posedge dst_clk) begin
      if (!dst_rst_n) begin
         req_s1_ff <= 1'b0;
         req_s2_ff <= 1'b0;
         req_s3_ff <= 1'b0;
         ack_ff <= 1'b0;
         dst_word <= '0;
      end else begin
         req_s1_ff <= req_ff;
         req_s2_ff <= req_s1_ff;
         req_s3_ff <= req_s2_ff;
         if (req_s2_ff == req_s3_ff && req_s3_ff != ack_ff) begin
            dst_word <= snap_ff;
            ack_ff <= req_s3_ff;
         end
      end
   end
endmodule // bstap_xfer

// ---- pkg/bstap_link_if.sv ----
// Link-side signals shared by the TAP core and its state machine
`timescale 1ns/1ns
interface bstap_link_if;
   import bstap_pkg::*;
   logic tck;
   logic rst;
   logic tms;
   bstap_state_t st;
   modport fsm (input tck, input rst, input tms, output st);
   modport core (output tck, output rst, output tms, input st);
endinterface

// ---- pkg/bstap_params.svh ----
// Reset values, capture pattern and opcodes of the boundary-scan TAP block
`ifndef BSTAP_PARAMS_SVH
`define BSTAP_PARAMS_SVH
`define BSTAP_INS_RESET 8'hFF
`define BSTAP_INS_CAPTURE 8'h81
`define BSTAP_CELL_RESET 18'h3_0000
`define BSTAP_CTRL_RESET 11'h002
`define BSTAP_OP_EXTEST 8'h00
`define BSTAP_OP_SAMPLE 8'h82
`define BSTAP_OP_INTEST 8'h03
`define BSTAP_OP_HIGHZ 8'h06
`define BSTAP_OP_CLAMP 8'h87
`define BSTAP_OP_RUNT 8'h09
`define BSTAP_OP_READBN 8'h0A
`define BSTAP_OP_CTRLSCAN 8'h8B
`endif

// ---- pkg/bstap_pkg.sv ----
// Types and opcode decode of the boundary-scan TAP block
`include "bstap_params.svh"
package bstap_pkg;
   typedef enum logic [3:0] {
      ST_TLR = 4'h0, ST_RTI = 4'h1, ST_SEL_DAT = 4'h2, ST_CAP_DAT = 4'h3,
      ST_SHF_DAT = 4'h4, ST_EX1_DAT = 4'h5, ST_PAU_DAT = 4'h6, ST_EX2_DAT = 4'h7,
      ST_UPD_DAT = 4'h8, ST_SEL_INS = 4'h9, ST_CAP_INS = 4'hA, ST_SHF_INS = 4'hB,
      ST_EX1_INS = 4'hC, ST_PAU_INS = 4'hD, ST_EX2_INS = 4'hE, ST_UPD_INS = 4'hF
   } bstap_state_t;

   typedef enum logic [1:0] {
      SEL_BYPASS = 2'h0, SEL_CELL = 2'h1, SEL_CTRL = 2'h2
   } bstap_sel_t;

   // Odd parity and unknown opcodes fall back to bypass
   function automatic bstap_sel_t bstap_select(input logic [7:0] op);
      bstap_sel_t sel;
      sel = SEL_BYPASS;
      if (!(^op)) begin
         case (op)
            `BSTAP_OP_EXTEST, `BSTAP_OP_SAMPLE,
            `BSTAP_OP_INTEST, `BSTAP_OP_READBN: sel = SEL_CELL;
            `BSTAP_OP_CTRLSCAN: sel = SEL_CTRL;
            default: sel = SEL_BYPASS;
         endcase
      end
      return sel;
   endfunction

   function automatic logic bstap_is_test(input logic [7:0] op);
      return !(^op) && (op == `BSTAP_OP_EXTEST || op == `BSTAP_OP_INTEST ||
         op == `BSTAP_OP_HIGHZ || op == `BSTAP_OP_CLAMP || op == `BSTAP_OP_RUNT);
   endfunction
endpackage

// ---- tb/bstap_tester.sv ----
// Behavioural boundary-scan tester that drives the test access port
`timescale 1ns/1ns
module bstap_tester (
   output logic TCK,
   output logic TMS,
   output logic TDI,
   input wire logic TDO,
   input wire logic TDO_OE
);
   logic tdo_s;
   logic oe_s;
   logic tdo_line;

   // Floating line reads as the inverse, so a missing enable corrupts the data
   assign tdo_line = TDO_OE ? TDO : ~TDO;

   // Pull-ups on the mode and data lines: idle level is high
   initial begin
      TCK = 1'b0;
      TMS = 1'b1;
      TDI = 1'b1;
      tdo_s = 1'b0;
      oe_s = 1'b0;
   end

   // Clock stands low between calls; lines move only while it is low
   task automatic step(input logic tms, input logic tdi);
      TMS = tms;
      TDI = tdi;
      #40 TCK = 1'b1;
      tdo_s = tdo_line;
      oe_s = TDO_OE;
      #40 TCK = 1'b0;
   endtask

   // Mode bits go out first bit first; offset keeps phase apart from CLK
   task automatic walk(input logic [15:0] tms, input int n);
      #7;
      for (int i = 0; i < n; i++) begin
         step(tms[i], 1'b1);
      end
   endtask

   // Shift n bits from the shift state; last bit leaves for Exit1
   task automatic shift(input int n, input logic [31:0] din, output logic [31:0] dout,
      output logic oe_ok);
      dout = '0;
      oe_ok = 1'b1;
      for (int i = 0; i < n; i++) begin
         step(i == n - 1, din[i]);
         dout[i] = tdo_s;
         oe_ok = oe_ok & oe_s;
      end
   endtask
endmodule // bstap_tester

// ---- tb/bstap_top_bench.sv ----
// Self-checking bench for the boundary-scan test access port
`timescale 1ns/1ns
`include "bstap_params.svh"
module bstap_top_bench;
   typedef struct {
      logic [7:0] op;
      logic tm;
      logic rt;
      int len;
   } bstap_row_t;

   localparam int NROW = 12;
   bstap_row_t rows [NROW] = '{
      '{`BSTAP_OP_SAMPLE, 1'b0, 1'b0, 18},
      '{`BSTAP_OP_EXTEST, 1'b1, 1'b0, 18},
      '{`BSTAP_OP_INTEST, 1'b1, 1'b0, 18},
      '{`BSTAP_OP_READBN, 1'b0, 1'b0, 18},
      '{`BSTAP_OP_CTRLSCAN, 1'b0, 1'b0, 11},
      '{`BSTAP_OP_HIGHZ, 1'b1, 1'b0, 1},
      '{`BSTAP_OP_CLAMP, 1'b1, 1'b0, 1},
      '{`BSTAP_OP_RUNT, 1'b1, 1'b1, 1},
      '{8'h84, 1'b0, 1'b0, 1},
      '{8'h02, 1'b0, 1'b0, 1},
      '{8'h80, 1'b0, 1'b0, 1},
      '{8'h81, 1'b0, 1'b0, 1}
   };

   logic clk;
   logic nrst;
   logic tck;
   logic tms;
   logic tdi;
   logic tdo;
   logic tdo_oe;
   logic [7:0] instr;
   logic test_mode;
   logic run_test;
   logic [17:0] cell_out;
   logic [10:0] ctrl_out;
   logic [31:0] got;
   logic [31:0] got2;
   logic [31:0] pat;
   logic [31:0] cap;
   logic [31:0] exp;
   logic [31:0] cell_m;
   logic [31:0] ctrl_m;
   logic oe;
   int error_cnt;
   int checked;

   bstap_top dut (
      .CLK(clk),
      .NRST(nrst),
      .TCK(tck),
      .TMS(tms),
      .TDI(tdi),
      .TDO(tdo),
      .TDO_OE(tdo_oe),
      .INSTR(instr),
      .TEST_MODE(test_mode),
      .RUN_TEST(run_test),
      .CELL_OUT(cell_out),
      .CTRL_OUT(ctrl_out)
   );

   bstap_tester u_tst (
      .TCK(tck),
      .TMS(tms),
      .TDI(tdi),
      .TDO(tdo),
      .TDO_OE(tdo_oe)
   );

   always #10 clk = ~clk;

   task automatic stop_test();
      $display("checks %0d errors %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   task automatic chk(input string name, input logic [31:0] e, input logic [31:0] g);
      checked++;
      if (g !== e) begin
         error_cnt++;
         $display("[ERR] %s expected %h seen %h", name, e, g);
      end
   endtask

   // Full scan from Run-Test/Idle back to Run-Test/Idle, then idle for the crossing
   task automatic scan(input logic ins, input int n, input logic [31:0] din,
      output logic [31:0] dout);
      logic ok;
      u_tst.walk(ins ? 16'h0003 : 16'h0001, ins ? 4 : 3);
      u_tst.shift(n, din, dout, ok);
      chk("oe_in_shift", 32'h1, 32'(ok));
      u_tst.step(1'b1, 1'b1);
      chk("oe_after_exit1", 32'h0, 32'(u_tst.oe_s));
      u_tst.step(1'b0, 1'b1);
      u_tst.walk(16'h0000, 10);
      @(negedge clk);
   endtask

   // Run is bounded well below the watchdog span
   initial begin
      #300000;
      error_cnt++;
      stop_test();
   end

   initial begin
      clk = 1'b0;
      nrst = 1'b0;
      error_cnt = 0;
      checked = 0;
      cell_m = 32'h0003_0000;
      ctrl_m = 32'h0000_0002;
      // Test clock must tick during reset for the synchroniser
      fork
         repeat (12) @(posedge clk);
         u_tst.walk(16'h00FF, 6);
      join
      chk("oe_in_reset", 32'h0, 32'(tdo_oe));
      chk("instr_in_reset", 32'h0, 32'(instr));
      chk("cell_in_reset", 32'h0, 32'(cell_out));
      @(posedge clk);
      nrst <= 1'b1;
      u_tst.walk(16'h003F, 7);
      u_tst.walk(16'h0000, 10);
      @(negedge clk);
      chk("instr_reset", 32'h0000_00FF, 32'(instr));
      chk("cell_reset", cell_m, 32'(cell_out));
      chk("ctrl_reset", ctrl_m, 32'(ctrl_out));
      chk("mode_reset", 32'h0, 32'(test_mode));
      for (int i = 0; i < NROW; i++) begin
         scan(1'b1, 8, 32'(rows[i].op), got);
         chk("ins_capture", 32'h0000_0081, got);
         chk("instr", 32'(rows[i].op), 32'(instr));
         chk("test_mode", 32'(rows[i].tm), 32'(test_mode));
         chk("run_test", 32'(rows[i].rt), 32'(run_test));
         pat = (32'h0005_A5C3 ^ (i * 32'h0001_3579)) & 32'h0007_FFFF;
         cap = (rows[i].len == 18) ? cell_m : (rows[i].len == 11) ? ctrl_m : 32'h0;
         scan(1'b0, 19, pat, got);
         exp = ((pat << rows[i].len) | cap) & 32'h0007_FFFF;
         chk("dr_out", exp, got);
         if (rows[i].len == 18) begin
            cell_m = (pat >> 1) & 32'h0003_FFFF;
         end
         if (rows[i].len == 11) begin
            ctrl_m = (pat >> 8) & 32'h0000_07FF;
         end
         chk("cell_out", cell_m, 32'(cell_out));
         chk("ctrl_out", ctrl_m, 32'(ctrl_out));
      end
      // Split boundary scan: pause, then back to shift from Exit2
      scan(1'b1, 8, 32'(`BSTAP_OP_SAMPLE), got);
      pat = 32'h0002_C3A5;
      u_tst.walk(16'h0001, 3);
      u_tst.shift(9, pat, got, oe);
      u_tst.walk(16'h0080, 9);
      u_tst.shift(9, pat >> 9, got2, oe);
      u_tst.walk(16'h0001, 12);
      @(negedge clk);
      chk("paused_out", cell_m, 32'({got2[8:0], got[8:0]}));
      cell_m = pat & 32'h0003_FFFF;
      chk("paused_cells", cell_m, 32'(cell_out));
      // Run enable only while idling with the run instruction
      scan(1'b1, 8, 32'(`BSTAP_OP_RUNT), got);
      u_tst.walk(16'h0005, 12);
      @(negedge clk);
      chk("run_in_pause", 32'h0, 32'(run_test));
      u_tst.walk(16'h0003, 13);
      @(negedge clk);
      chk("run_in_idle", 32'h1, 32'(run_test));
      // Five high mode bits from Pause-IR, passing an update on the way
      u_tst.walk(16'h000B, 5);
      u_tst.walk(16'h001F, 16);
      @(negedge clk);
      chk("instr_tlr", 32'h0000_00FF, 32'(instr));
      chk("cell_tlr", 32'h0003_0000, 32'(cell_out));
      chk("ctrl_tlr", 32'h0000_0002, 32'(ctrl_out));
      chk("mode_tlr", 32'h0, 32'(test_mode));
      stop_test();
   end
endmodule // bstap_top_bench
